// *** rtl/qdc_pkg.sv ***
// shared constants and types for the quad converter serial load path
package qdc_pkg;

    // serial frame: two channel address bits, then sixteen data bits
    localparam int ADDR_BITS   = 2;
    localparam int DATA_BITS   = 16;
    localparam int FRAME_BITS  = ADDR_BITS + DATA_BITS;
    localparam int N_CHAN      = 4;
    localparam int CHAIN_DELAY = 19;

    // codes loaded by preset and power-on reset
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [15:0] HALF_CODE = 16'h8000;

    // host pads each frame to whole bytes, right justified
    localparam int BYTE_PAD_BITS = 6;

    // timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int SCLK_PERIOD_NS = 320;
    localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                    / (2 * CLK_PERIOD_NS);
    localparam int CS_GAP_CYC     = 2 * SCLK_HALF_CYC;

    // input synchroniser lanes of the device
    localparam int SYNC_W  = 6;
    localparam int SI_SCLK = 0;
    localparam int SI_CS   = 1;
    localparam int SI_SDI  = 2;
    localparam int SI_LOAD = 3;
    localparam int SI_PRE  = 4;
    localparam int SI_LVL  = 5;
    // idle levels: select, strobe and preset high, others low
    localparam logic [5:0] SYNC_RST = 6'h1a;

    // cycles the reset preset is held while the level pin settles
    localparam logic [2:0] INIT_HOLD = 3'h5;

    typedef enum logic [1:0] {
        QDC_IDLE = 2'b00,
        QDC_LOW  = 2'b01,
        QDC_HIGH = 2'b10,
        QDC_GAP  = 2'b11
    } qdc_host_state_t;

endpackage

// *** rtl/qdc_link_if.sv ***
// serial link between the converter control and its host
`timescale 1ns/100ps
interface qdc_link_if;
    logic sclk;
    logic cs_n;
    logic serial_in;
    logic serial_chain_out;
    logic load_all_strobe_n;
    logic preset_n;

    modport dev (
        input  sclk,
        input  cs_n,
        input  serial_in,
        input  load_all_strobe_n,
        input  preset_n,
        output serial_chain_out
    );

    modport host (
        output sclk,
        output cs_n,
        output serial_in,
        output load_all_strobe_n,
        output preset_n,
        input  serial_chain_out
    );
endinterface

// *** rtl/qdc_fifo.sv ***
// synchronous valid/ready fifo for frames waiting to be shifted
`timescale 1ns/100ps
module qdc_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_reg;
    logic [AW:0]  wr_next;
    logic [AW:0]  rd_reg;
    logic [AW:0]  rd_next;
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    assign empty     = (wr_reg == rd_reg);
    assign full      = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_reg[AW-1:0]];
    assign push      = in_valid & ~full;
    assign pop       = out_ready & ~empty;

    always_comb begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

// *** rtl/qdc_host.sv ***
// host end: queues channel writes and shifts them out over the link
`timescale 1ns/100ps
module qdc_host
    import qdc_pkg::*;
#(
    parameter int PAD_BITS   = BYTE_PAD_BITS,
    parameter int FIFO_DEPTH = 16,
    parameter int HALF_CYC   = SCLK_HALF_CYC,
    parameter int GAP_CYC    = CS_GAP_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 wr_valid,
    output logic                      wr_ready,
    input  wire logic [ADDR_BITS-1:0] wr_chan,
    input  wire logic [DATA_BITS-1:0] wr_data,
    input  wire logic                 load_req,
    input  wire logic                 preset_req,
    output logic [FRAME_BITS-1:0]     echo_word,
    qdc_link_if.host                  link
);
    localparam int SH_W = FRAME_BITS + PAD_BITS;

    qdc_host_state_t        state_reg;
    qdc_host_state_t        state_next;
    logic [15:0]            div_reg;
    logic [15:0]            div_next;
    logic [7:0]             bits_reg;
    logic [7:0]             bits_next;
    logic [SH_W-1:0]        sh_reg;
    logic [SH_W-1:0]        sh_next;
    logic                   sclk_reg;
    logic                   sclk_next;
    logic                   cs_n_reg;
    logic                   cs_n_next;
    logic                   load_n_reg;
    logic                   preset_n_reg;
    logic [FRAME_BITS-1:0]  echo_reg;
    logic [FRAME_BITS-1:0]  echo_next;
    logic [2:0]             sdo_sync_reg;
    logic                   sdo_filt_reg;
    logic                   sdo_filt_next;
    logic                   fifo_valid;
    logic [FRAME_BITS-1:0]  fifo_data;
    logic                   pop;

    qdc_fifo #(.W(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_chan, wr_data}),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    assign sdo_filt_next = (sdo_sync_reg[1] == sdo_sync_reg[2]) ? sdo_sync_reg[2] : sdo_filt_reg;

    always_comb begin
        state_next = state_reg;
        div_next   = div_reg;
        bits_next  = bits_reg;
        sh_next    = sh_reg;
        sclk_next  = sclk_reg;
        cs_n_next  = cs_n_reg;
        echo_next  = echo_reg;
        pop        = 1'b0;
        case (state_reg)
            QDC_IDLE: begin
                if (fifo_valid) begin
                    // pad bits lead, frame sits right justified
                    sh_next                   = '0;
                    sh_next[FRAME_BITS-1:0]   = fifo_data;
                    bits_next                 = 8'(SH_W);
                    cs_n_next                 = 1'b0;
                    div_next                  = '0;
                    pop                       = 1'b1;
                    state_next                = QDC_LOW;
                end
            end
            QDC_LOW: begin
                if (div_reg == 16'(HALF_CYC - 1)) begin
                    div_next   = '0;
                    sclk_next  = 1'b1;
                    echo_next  = {echo_reg[FRAME_BITS-2:0], sdo_filt_reg};
                    state_next = QDC_HIGH;
                end else begin
                    div_next = div_reg + 16'h0001;
                end
            end
            QDC_HIGH: begin
                if (div_reg == 16'(HALF_CYC - 1)) begin
                    div_next  = '0;
                    sclk_next = 1'b0;
                    bits_next = bits_reg - 8'h01;
                    if (bits_reg == 8'h01) begin
                        // select rises half a period after the last rising edge
                        cs_n_next  = 1'b1;
                        state_next = QDC_GAP;
                    end else begin
                        sh_next    = {sh_reg[SH_W-2:0], 1'b0};
                        state_next = QDC_LOW;
                    end
                end else begin
                    div_next = div_reg + 16'h0001;
                end
            end
            QDC_GAP: begin
                if (div_reg == 16'(GAP_CYC - 1)) begin
                    div_next   = '0;
                    state_next = QDC_IDLE;
                end else begin
                    div_next = div_reg + 16'h0001;
                end
            end
            default: begin
                state_next = QDC_IDLE;
                cs_n_next  = 1'b1;
                sclk_next  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= QDC_IDLE;
            div_reg      <= '0;
            bits_reg     <= '0;
            sh_reg       <= '0;
            sclk_reg     <= 1'b0;
            cs_n_reg     <= 1'b1;
            load_n_reg   <= 1'b1;
            preset_n_reg <= 1'b1;
            echo_reg     <= '0;
            sdo_sync_reg <= '0;
            sdo_filt_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            div_reg      <= div_next;
            bits_reg     <= bits_next;
            sh_reg       <= sh_next;
            sclk_reg     <= sclk_next;
            cs_n_reg     <= cs_n_next;
            load_n_reg   <= ~load_req;
            preset_n_reg <= ~preset_req;
            echo_reg     <= echo_next;
            sdo_sync_reg <= {sdo_sync_reg[1:0], link.serial_chain_out};
            sdo_filt_reg <= sdo_filt_next;
        end
    end

    assign link.sclk              = sclk_reg;
    assign link.cs_n              = cs_n_reg;
    assign link.serial_in         = sh_reg[SH_W-1];
    assign link.load_all_strobe_n = load_n_reg;
    assign link.preset_n          = preset_n_reg;
    assign echo_word              = echo_reg;
endmodule

// *** rtl/qdc_device.sv ***
// device end: serial shift, input and converter registers of a quad converter
// Function
// - shift data in on serial clock rise
// - shift only while select is low
// - only the newest frame bits are used
// - most significant bit travels first
// - select rise loads addressed input register
// - preset pin loads zero or half scale
// - power-on reset loads zero or half scale
// - converter holds preset until a later load
// - load strobe updates all four channels together
// - host may send three right-justified bytes
// - host may send four right-justified bytes
// - unused preset pin is held high
// - four channels, input and converter registers
// - address 00..11 selects channel A..D
// - frame is two address then sixteen data
// - strobe low transparent, high latched, select-independent
// - chain output lags input by nineteen edges
`timescale 1ns/100ps
module qdc_device
    import qdc_pkg::*;
(
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    qdc_link_if.dev                                link,
    input  wire logic                              half_scale_sel,
    output logic [N_CHAN-1:0][DATA_BITS-1:0]       input_code,
    output logic [N_CHAN-1:0][DATA_BITS-1:0]       dac_code,
    output logic                                   preset_active
);

    // synchroniser: three stages, a change counts once stages two and three agree
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    logic [SYNC_W-1:0] s3_reg;
    logic [SYNC_W-1:0] filt_reg;
    logic [SYNC_W-1:0] filt_next;
    logic [SYNC_W-1:0] prev_reg;
    logic [SYNC_W-1:0] s1_next;
    logic [SYNC_W-1:0] s2_next;
    logic [SYNC_W-1:0] s3_next;
    logic [SYNC_W-1:0] prev_next;

    assign raw[SI_SCLK] = link.sclk;
    assign raw[SI_CS]   = link.cs_n;
    assign raw[SI_SDI]  = link.serial_in;
    assign raw[SI_LOAD] = link.load_all_strobe_n;
    assign raw[SI_PRE]  = link.preset_n;
    assign raw[SI_LVL]  = half_scale_sel;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            assign filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
        end
    endgenerate

    // every lane has the same latency, so select and clock keep their order
    always_comb begin
        s1_next   = raw;
        s2_next   = s1_reg;
        s3_next   = s2_reg;
        prev_next = filt_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_reg   <= SYNC_RST;
            s2_reg   <= SYNC_RST;
            s3_reg   <= SYNC_RST;
            filt_reg <= SYNC_RST;
            prev_reg <= SYNC_RST;
        end else begin
            s1_reg   <= s1_next;
            s2_reg   <= s2_next;
            s3_reg   <= s3_next;
            filt_reg <= filt_next;
            prev_reg <= prev_next;
        end
    end

    // edge and level decode of the filtered link
    logic sclk_rise;
    logic cs_rise;
    logic cs_low;
    logic sdi_bit;
    logic load_low;
    logic preset_low;
    logic level_half;

    assign sclk_rise  = filt_reg[SI_SCLK] & ~prev_reg[SI_SCLK];
    assign cs_rise    = filt_reg[SI_CS] & ~prev_reg[SI_CS];
    assign cs_low     = ~filt_reg[SI_CS];
    assign sdi_bit    = filt_reg[SI_SDI];
    assign load_low   = ~filt_reg[SI_LOAD];
    assign preset_low = ~filt_reg[SI_PRE];
    assign level_half = filt_reg[SI_LVL];

    // shift register and chain output stage
    logic [FRAME_BITS-1:0] sr_reg;
    logic [FRAME_BITS-1:0] sr_next;
    logic                  chain_reg;
    logic                  chain_next;

    always_comb begin
        sr_next    = sr_reg;
        chain_next = chain_reg;
        // a short frame leaves stale bits in place; nothing flags it
        if (sclk_rise && cs_low) begin
            // earliest bit ends up on top; older bits fall off the end
            sr_next    = {sr_reg[FRAME_BITS-2:0], sdi_bit};
            // eighteen stages plus this one give the chain lag
            chain_next = sr_reg[FRAME_BITS-1];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sr_reg    <= '0;
            chain_reg <= 1'b0;
        end else begin
            sr_reg    <= sr_next;
            chain_reg <= chain_next;
        end
    end

    // power-on preset: the level pin is only known once synchronised,
    // so the preset is held for a few cycles after reset release
    // the level pin must be settled by the time reset is released
    logic [2:0] init_reg;
    logic [2:0] init_next;
    logic       preset_now;
    logic       preset_act_reg;
    logic       preset_act_next;

    assign preset_now = preset_low || (init_reg != 3'h0);

    always_comb begin
        init_next       = init_reg;
        preset_act_next = preset_now;
        if (init_reg != 3'h0) begin
            init_next = init_reg - 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            init_reg       <= INIT_HOLD;
            preset_act_reg <= 1'b1;
        end else begin
            init_reg       <= init_next;
            preset_act_reg <= preset_act_next;
        end
    end

    // channel registers
    logic [N_CHAN-1:0][DATA_BITS-1:0] in_reg;
    logic [N_CHAN-1:0][DATA_BITS-1:0] in_next;
    logic [N_CHAN-1:0][DATA_BITS-1:0] dac_reg;
    logic [N_CHAN-1:0][DATA_BITS-1:0] dac_next;
    logic [DATA_BITS-1:0]             preset_code;
    logic [ADDR_BITS-1:0]             frame_chan;
    logic [DATA_BITS-1:0]             frame_data;

    assign preset_code = level_half ? HALF_CODE : ZERO_CODE;
    // top two bits are the channel, low sixteen the code
    assign frame_chan  = sr_reg[FRAME_BITS-1 -: ADDR_BITS];
    assign frame_data  = sr_reg[DATA_BITS-1:0];

    always_comb begin
        in_next  = in_reg;
        dac_next = dac_reg;
        // preset wins over a select rise or strobe in the same cycle
        if (preset_now) begin
            for (int i = 0; i < N_CHAN; i++) begin
                in_next[i]  = preset_code;
                dac_next[i] = preset_code;
            end
        end else begin
            // only a select rise writes an input register
            if (cs_rise) begin
                in_next[frame_chan] = frame_data;
            end
            // strobe is looked at regardless of select
            if (load_low) begin
                dac_next = in_next;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            in_reg  <= '0;
            dac_reg <= '0;
        end else begin
            in_reg  <= in_next;
            dac_reg <= dac_next;
        end
    end

    assign link.serial_chain_out = chain_reg;
    assign input_code            = in_reg;
    assign dac_code              = dac_reg;
    assign preset_active         = preset_act_reg;
endmodule

// *** bench/qdc_sva.sv ***
// assertions on the serial link and the converter codes
`timescale 1ns/100ps
module qdc_sva
    import qdc_pkg::*;
(
    input wire logic                        core_clk,
    input wire logic                        rst,
    input wire logic                        sclk,
    input wire logic                        cs_n,
    input wire logic                        serial_in,
    input wire logic                        load_all_strobe_n,
    input wire logic                        preset_n,
    input wire logic                        half_scale_sel,
    input wire logic                        preset_active,
    input wire logic [N_CHAN-1:0][DATA_BITS-1:0] input_code,
    input wire logic [N_CHAN-1:0][DATA_BITS-1:0] dac_code
);
    logic [5:0]  rise_cnt_reg;
    logic [5:0]  rise_cnt_next;
    logic        sclk_d_reg;
    logic        sclk_d_next;
    logic [15:0] pcode;

    assign pcode = half_scale_sel ? HALF_CODE : ZERO_CODE;

    // rises counted per frame, read at the select rise before clearing
    always_comb begin
        sclk_d_next   = sclk;
        rise_cnt_next = rise_cnt_reg;
        if (cs_n) begin
            rise_cnt_next = 6'h00;
        end else if (sclk && !sclk_d_reg) begin
            rise_cnt_next = rise_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rise_cnt_reg <= 6'h00;
            sclk_d_reg   <= 1'b0;
        end else begin
            rise_cnt_reg <= rise_cnt_next;
            sclk_d_reg   <= sclk_d_next;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    data_hold_a: assert property (
        sclk && $past(sclk) |-> $stable(serial_in))
        else $error("serial data moved while clock high");
    clk_high_a: assert property (
        $rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high time wrong");
    idle_clk_a: assert property (
        cs_n |-> !sclk)
        else $error("serial clock active while deselected");
    frame_lead_a: assert property (
        $fell(cs_n) |-> !sclk [*4] ##1 sclk)
        else $error("first clock rise misplaced");
    frame_len_a: assert property (
        $rose(cs_n) |-> rise_cnt_reg == 6'h18)
        else $error("frame is not three bytes");
    in_hold_a: assert property (
        !cs_n && !$past(cs_n, 8) && preset_n && $past(preset_n, 8) && !preset_active
        |-> $stable(input_code))
        else $error("input code changed during shifting");
    dac_latch_a: assert property (
        load_all_strobe_n && $past(load_all_strobe_n, 7) && preset_n && $past(preset_n, 7)
        && !preset_active && !$past(preset_active) |-> $stable(dac_code))
        else $error("converter code moved while latched");
    dac_follow_a: assert property (
        !load_all_strobe_n && !$past(load_all_strobe_n, 7) && !preset_active
        |-> dac_code == input_code)
        else $error("converter code not following input");
    preset_val_a: assert property (
        !preset_n && !$past(preset_n, 7) && half_scale_sel == $past(half_scale_sel, 7)
        |-> input_code == {N_CHAN{pcode}} && dac_code == {N_CHAN{pcode}})
        else $error("preset code wrong");
    init_val_a: assert property (
        $fell(preset_active) |-> input_code == {N_CHAN{pcode}} && dac_code == {N_CHAN{pcode}})
        else $error("code after reset wrong");
endmodule

// *** bench/tb_top.sv ***
// self-checking bench: host and device joined over the serial link
`timescale 1ns/100ps
module tb_top
    import qdc_pkg::*;
;
    logic                             core_clk = 1'b0;
    logic                             rst, wr_valid, wr_ready, load_req, preset_req;
    logic                             half_scale_sel, preset_active, saw_full;
    logic [1:0]                       wr_chan;
    logic [15:0]                      wr_data;
    logic [FRAME_BITS-1:0]            echo_word;
    logic [N_CHAN-1:0][DATA_BITS-1:0] input_code, dac_code;
    logic [15:0]                      exp_in [N_CHAN];
    logic [15:0]                      exp_dac [N_CHAN];
    int                               num_errors, comparisons, cycles;
    int unsigned                      seed_val;
    logic [CHAIN_DELAY-1:0]           sdi_hist;

    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    qdc_link_if u_qdc_link_if ();
    qdc_host u_qdc_host (.core_clk(core_clk), .rst(rst), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_chan(wr_chan), .wr_data(wr_data), .load_req(load_req),
        .preset_req(preset_req), .echo_word(echo_word), .link(u_qdc_link_if));
    qdc_device u_qdc_device (.core_clk(core_clk), .rst(rst), .link(u_qdc_link_if),
        .half_scale_sel(half_scale_sel), .input_code(input_code), .dac_code(dac_code),
        .preset_active(preset_active));
    qdc_sva u_qdc_sva (.core_clk(core_clk), .rst(rst), .sclk(u_qdc_link_if.sclk),
        .cs_n(u_qdc_link_if.cs_n), .serial_in(u_qdc_link_if.serial_in),
        .load_all_strobe_n(u_qdc_link_if.load_all_strobe_n),
        .preset_n(u_qdc_link_if.preset_n), .half_scale_sel(half_scale_sel),
        .preset_active(preset_active), .input_code(input_code), .dac_code(dac_code));

    function automatic logic [15:0] pcode(input logic sel);
        return sel ? HALF_CODE : ZERO_CODE;
    endfunction

    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_codes();
        for (int c = 0; c < N_CHAN; c++) begin
            check(input_code[c], exp_in[c]);
            check(dac_code[c], exp_dac[c]);
        end
    endtask

    // entered just after a rising edge; ready is read at the falling edge
    task automatic push(input logic [1:0] ch, input logic [15:0] d);
        wr_valid <= 1'b1;
        wr_chan  <= ch;
        wr_data  <= d;
        @(negedge core_clk);
        while (wr_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        exp_in[ch] = d;
    endtask

    // long quiet select means the queue has drained
    task automatic wait_idle();
        int quiet;
        quiet = 0;
        while (quiet < 300) begin
            @(posedge core_clk);
            quiet = (u_qdc_link_if.cs_n === 1'b1) ? quiet + 1 : 0;
        end
    endtask

    task automatic do_reset(input logic sel);
        half_scale_sel <= sel;
        rst            <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (12) @(posedge core_clk);
        exp_in  = '{default: pcode(sel)};
        exp_dac = '{default: pcode(sel)};
        check_codes();
    endtask

    task automatic preset_to(input logic sel);
        half_scale_sel <= sel;
        repeat (8) @(posedge core_clk);
        preset_req <= 1'b1;
        repeat (12) @(posedge core_clk);
        exp_in  = '{default: pcode(sel)};
        exp_dac = '{default: pcode(sel)};
        check_codes();
        preset_req <= 1'b0;
        repeat (10) @(posedge core_clk);
        check_codes();
    endtask

    always @(negedge core_clk) begin
        if (wr_valid && wr_ready === 1'b0) begin
            saw_full = 1'b1;
        end
    end

    // chain pin must show what entered nineteen link clock rises earlier
    always @(posedge u_qdc_link_if.sclk or posedge rst) begin
        if (rst) begin
            sdi_hist <= '0;
        end else begin
            check(16'(u_qdc_link_if.serial_chain_out), 16'(sdi_hist[CHAIN_DELAY-1]));
            sdi_hist <= {sdi_hist[CHAIN_DELAY-2:0], u_qdc_link_if.serial_in};
        end
    end

    // a frame takes about 200 cycles; the whole run about 6000
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 12000) begin
            num_errors++;
            $display("MISMATCH at %0t: run did not finish", $time);
            results();
        end
    end

    initial begin
        logic [15:0] d;
        rst            = 1'b1;
        wr_valid       = 1'b0;
        wr_chan        = 2'h0;
        wr_data        = 16'h0000;
        load_req       = 1'b0;
        preset_req     = 1'b0;
        half_scale_sel = 1'b1;
        saw_full       = 1'b0;
        seed_val       = $urandom(32'h9ae7);
        do_reset(1'b1);
        // strobe latched: writes reach input registers only
        for (int c = 0; c < N_CHAN; c++) begin
            d = (c == 0) ? 16'hffff : (c == 3) ? 16'h0001 : 16'($urandom());
            push(2'(c), d);
        end
        wr_valid <= 1'b0;
        wait_idle();
        check_codes();
        // host echo trails the chain pin by one link clock through its synchroniser
        check(echo_word[17:2], {exp_in[2][13:0], 2'b00});
        check({14'h0000, echo_word[1:0]}, 16'h0000);
        load_req <= 1'b1;
        repeat (12) @(posedge core_clk);
        exp_dac = exp_in;
        check_codes();
        // burst larger than the queue while the link drains slowly
        for (int i = 0; i < 20; i++) begin
            push(2'($urandom()), 16'($urandom()));
        end
        wr_valid <= 1'b0;
        wait_idle();
        exp_dac = exp_in;
        check_codes();
        check({15'h0000, saw_full}, 16'h0001);
        load_req <= 1'b0;
        preset_to(1'b0);
        preset_to(1'b1);
        push(2'h2, 16'h5a5a);
        wr_valid <= 1'b0;
        wait_idle();
        check_codes();
        do_reset(1'b0);
        results();
    end
endmodule
